// [design/serial_shift_pkg.sv]
package serial_shift_pkg;
  // Register indices on the internal register port
  localparam logic [1:0] REG_DATA   = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_CTRL   = 2'h2;
  localparam logic [1:0] REG_BUFFER = 2'h3;
  // Status fields
  localparam int ST_START_BIT = 7;
  localparam int ST_OVF_BIT   = 6;
  localparam int ST_STOP_BIT  = 5;
  localparam int ST_COLL_BIT  = 4;
  // Control fields
  localparam int CT_WM_HI     = 5;
  localparam int CT_WM_LO     = 4;
  localparam int CT_CS_HI     = 3;
  localparam int CT_CS_LO     = 2;
  localparam int CT_CLK_BIT   = 1;
  localparam int CT_TGL_BIT   = 0;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [3:0] CNT_MAX   = 4'hF;
  localparam logic [3:0] CNT_ZERO  = 4'h0;
  // Wire modes
  localparam logic [1:0] WM_OFF   = 2'h0;
  localparam logic [1:0] WM_THREE = 2'h1;
  localparam logic [1:0] WM_TWO   = 2'h2;
  localparam logic [1:0] WM_TWO_H = 2'h3;
  // Clock selects
  localparam logic [1:0] CS_SOFT  = 2'h0;
  localparam logic [1:0] CS_TIMER = 2'h1;
  localparam logic [1:0] CS_EXT_P = 2'h2;
  localparam logic [1:0] CS_EXT_N = 2'h3;
  // Start detector SDA delay
  localparam int SDA_DLY_MIN_NS = 50;
  localparam int SDA_DLY_MAX_NS = 300;
  localparam int CLK_PERIOD_NS  = 40;
  localparam int SDA_DLY_CYC    =
    (SDA_DLY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [1:0] wire_mode;
    logic [1:0] clk_sel;
  } mode_t;
endpackage

// [design/byte_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
    $error("byte_fifo: DEPTH must be a power of two >= 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_ff;
  logic [AW:0]      rp_ff;
  wire              push  = in_valid && in_ready;
  wire              pop   = out_valid && out_ready;
  assign in_ready  = (wp_ff - rp_ff) != (AW+1)'(DEPTH);
  assign out_valid = wp_ff != rp_ff;
  assign out_data  = mem[rp_ff[AW-1:0]];
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wp_ff[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      wp_ff <= wp_ff + (AW+1)'(push);
      rp_ff <= rp_ff + (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// [design/serial_shift_two_wire_unit.sv]
`timescale 1ns/10ps
`default_nettype none
module serial_shift_two_wire_unit
  import serial_shift_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire reg_req_t   reg_req,
  output logic [7:0]      reg_rdata,
  input  wire logic       timer_match,
  input  wire logic       serial_clock_pin_in,
  input  wire logic       serial_in_pin,
  input  wire logic       port_data_out_bit,
  input  wire logic       port_clock_out_bit,
  input  wire logic       data_out_dir,
  input  wire logic       clock_dir,
  output logic            data_out_pin_out,
  output logic            data_out_pin_oe,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            scl_out,
  output logic            scl_oe,
  output logic            counter_overflow_out,
  output logic            start_detect_out,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data
);
  if (FIFO_DEPTH < 2) begin
    $error("FIFO_DEPTH too small");
  end

  // Pin synchronisers
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic       scl_prev_ff;
  logic [SDA_DLY_CYC-1:0] sda_dly_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_prev_ff <= 1'b1;
      sda_dly_ff  <= '1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], serial_clock_pin_in};
      sda_sync_ff <= {sda_sync_ff[0], serial_in_pin};
      scl_prev_ff <= scl_sync_ff[1];
      sda_dly_ff  <= {sda_dly_ff[SDA_DLY_CYC-2:0], sda_sync_ff[1]};
    end
  end
  wire scl_s    = scl_sync_ff[1];
  wire sda_s    = sda_sync_ff[1];
  wire sda_d    = sda_dly_ff[SDA_DLY_CYC-1];
  wire sda_dp;
  logic sda_dp_ff;
  assign sda_dp = sda_dp_ff;
  wire scl_rise = scl_s && !scl_prev_ff;
  wire scl_fall = !scl_s && scl_prev_ff;

  // Control state
  logic [7:0] data_ff;
  logic [7:0] buf_ff;
  logic [3:0] cnt_ff;
  logic       start_ff;
  logic       ovf_ff;
  logic       stop_ff;
  logic       hold_start_ff;
  logic       ovf_hold_ff;
  logic       latch_ff;
  logic       clk_tgl_ff;
  mode_t      mode_ff;

  wire [1:0] wm      = mode_ff.wire_mode;
  wire [1:0] cs      = mode_ff.clk_sel;
  wire       two_wire = wm[1];
  wire       ext_clk = cs[1];
  wire wr_data   = reg_req.wr && reg_req.addr == REG_DATA;
  wire wr_status = reg_req.wr && reg_req.addr == REG_STATUS;
  wire wr_ctrl   = reg_req.wr && reg_req.addr == REG_CTRL;
  wire strobe_clk = wr_ctrl && reg_req.wdata[CT_CLK_BIT];
  wire strobe_tgl = wr_ctrl && reg_req.wdata[CT_TGL_BIT];

  // Clock source selection
  wire sample_edge = (cs == CS_EXT_P) ? scl_rise : scl_fall;
  wire pin_edge    = scl_rise || scl_fall;
  wire ext_shift   = ext_clk && (sample_edge ||
                     (strobe_clk && strobe_tgl));
  wire shift_en    = ext_clk ? ext_shift :
                     (cs == CS_TIMER ? timer_match : strobe_clk);
  wire cnt_en      = ext_clk ? (pin_edge || (strobe_clk && strobe_tgl))
                     : (cs == CS_TIMER ? timer_match
                        : (strobe_clk || strobe_tgl));
  wire cnt_wrap    = cnt_en && cnt_ff == CNT_MAX;
  wire start_det   = two_wire && scl_s && !sda_d && sda_dp;
  wire stop_det    = two_wire && scl_s && sda_d && !sda_dp;
  wire clr_start   = wr_status && reg_req.wdata[ST_START_BIT];
  wire clr_ovf     = wr_status && reg_req.wdata[ST_OVF_BIT];
  wire clr_stop    = wr_status && reg_req.wdata[ST_STOP_BIT];

  // Data register and counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_ff <= RST_BYTE;
      cnt_ff  <= CNT_ZERO;
      mode_ff <= '0;
      buf_ff  <= RST_BYTE;
      sda_dp_ff <= 1'b1;
    end else begin
      sda_dp_ff <= sda_d;
      if (wr_data) begin
        data_ff <= reg_req.wdata;
      end else if (shift_en) begin
        data_ff <= {data_ff[6:0], sda_s};
      end
      if (wr_status) begin
        cnt_ff <= reg_req.wdata[3:0];
      end else if (cnt_en) begin
        cnt_ff <= cnt_ff + 4'h1;
      end
      if (wr_ctrl) begin
        mode_ff <= '{wire_mode: reg_req.wdata[CT_WM_HI:CT_WM_LO],
                     clk_sel:   reg_req.wdata[CT_CS_HI:CT_CS_LO]};
      end
      if (cnt_wrap) begin
        buf_ff <= shift_en ? {data_ff[6:0], sda_s} : data_ff;
      end
    end
  end

  // Flags and holds; set wins over clear, but a start clear beats the start hold set on an SCL fall
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_ff      <= 1'b0;
      ovf_ff        <= 1'b0;
      stop_ff       <= 1'b0;
      hold_start_ff <= 1'b0;
      ovf_hold_ff   <= 1'b0;
    end else begin
      start_ff <= start_det || (start_ff && !clr_start);
      ovf_ff   <= cnt_wrap || (ovf_ff && !clr_ovf);
      stop_ff  <= stop_det || (stop_ff && !clr_stop);
      if (!two_wire || (clr_start && !start_det)) begin
        hold_start_ff <= 1'b0;
      end else if (start_ff && scl_fall) begin
        hold_start_ff <= 1'b1;
      end
      if (wm != WM_TWO_H || (clr_ovf && !cnt_wrap)) begin
        ovf_hold_ff <= 1'b0;
      end else if (cnt_wrap) begin
        ovf_hold_ff <= 1'b1;
      end
    end
  end

  // Output latch and clock toggle
  wire latch_open = !ext_clk || !scl_s;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_ff   <= 1'b1;
      clk_tgl_ff <= 1'b0;
    end else begin
      if (latch_open) begin
        latch_ff <= wr_data ? reg_req.wdata[7] : data_ff[7];
      end
      if (strobe_tgl) begin
        clk_tgl_ff <= !clk_tgl_ff;
      end
    end
  end

  // Pin drive
  wire three_wire = wm == WM_THREE;
  wire scl_hold   = hold_start_ff || ovf_hold_ff;
  wire sda_low    = !latch_ff || !port_data_out_bit;
  assign data_out_pin_out = latch_ff;
  assign data_out_pin_oe  = three_wire && data_out_dir;
  assign sda_out          = 1'b0;
  assign sda_oe           = two_wire && data_out_dir && sda_low;
  assign scl_out          = 1'b0;
  assign scl_oe           = two_wire &&
                            (scl_hold ||
                             (clock_dir &&
                              !(port_clock_out_bit ^ clk_tgl_ff)));
  assign counter_overflow_out = ovf_ff;
  assign start_detect_out     = start_ff;

  // Received bytes stream into the FIFO on each overflow that finds it not full
  logic fifo_in_ready;
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (cnt_wrap),
    .in_ready  (fifo_in_ready),
    .in_data   (shift_en ? {data_ff[6:0], sda_s} : data_ff),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // Register readback
  wire coll = two_wire && (data_ff[7] != sda_s);
  wire [7:0] status_rd = {start_ff, ovf_ff, stop_ff, coll, cnt_ff};
  wire [7:0] ctrl_rd   = {2'h0, wm, cs, 2'h0};
  always_comb begin
    case (reg_req.addr)
      REG_DATA:   reg_rdata = data_ff;
      REG_STATUS: reg_rdata = status_rd;
      REG_CTRL:   reg_rdata = ctrl_rd;
      REG_BUFFER: reg_rdata = buf_ff;
      default:    reg_rdata = RST_BYTE;
    endcase
  end
  wire unused_ok = fifo_in_ready | reg_req.rd | latch_open | sda_dp;
endmodule
`default_nettype wire

// [dv/serial_shift_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module serial_shift_monitor
  import serial_shift_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire reg_req_t   reg_req,
  input wire logic       port_data_out_bit,
  input wire logic       data_out_dir,
  input wire logic       clock_dir,
  input wire logic       data_out_pin_out,
  input wire logic       data_out_pin_oe,
  input wire logic       sda_oe,
  input wire logic       scl_oe,
  input wire logic       counter_overflow_out,
  input wire logic       start_detect_out,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic [7:0] rx_data
);
  mode_t mode_ff;
  logic  st_wr;
  assign st_wr = reg_req.wr && reg_req.addr == REG_STATUS;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      mode_ff <= '0;
    else if (reg_req.wr && reg_req.addr == REG_CTRL)
      mode_ff <= reg_req.wdata[5:2];
  end
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  off_quiet_a: assert property (
    mode_ff.wire_mode == WM_OFF |-> !sda_oe && !scl_oe && !data_out_pin_oe)
    else $error("output on in mode off");
  dir_gate_a: assert property (
    !data_out_dir |-> !data_out_pin_oe) else $error("data out without dir");
  sda_pull_a: assert property (
    mode_ff.wire_mode[1] && data_out_dir && !port_data_out_bit
    |-> ##[0:1] sda_oe) else $error("sda not pulled low");
  start_keep_a: assert property (
    start_detect_out && !(st_wr && reg_req.wdata[ST_START_BIT])
    |=> start_detect_out) else $error("start flag lost");
  ovf_keep_a: assert property (
    counter_overflow_out && !(st_wr && reg_req.wdata[ST_OVF_BIT])
    |=> counter_overflow_out) else $error("overflow flag lost");
  rx_hold_a: assert property (
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("rx word not held");
  ovf_hold_a: assert property (
    counter_overflow_out && clock_dir && !reg_req.wr
    && mode_ff.wire_mode == WM_TWO_H |=> scl_oe)
    else $error("scl not held after overflow");
  msb_now_a: assert property (
    reg_req.wr && reg_req.addr == REG_DATA && data_out_dir
    && mode_ff == {WM_THREE, CS_SOFT}
    |=> data_out_pin_out == $past(reg_req.wdata[7]))
    else $error("data out not new msb");
endmodule
bind serial_shift_two_wire_unit serial_shift_monitor mon (
  .ref_clk, .rst_n, .reg_req, .port_data_out_bit, .data_out_dir,
  .clock_dir, .data_out_pin_out, .data_out_pin_oe, .sda_oe, .scl_oe,
  .counter_overflow_out, .start_detect_out, .rx_valid, .rx_ready, .rx_data);
`default_nettype wire

// [dv/two_wire_master_model.sv]
`timescale 1ns/10ps
`default_nettype none
module two_wire_master_model (
  input  wire logic ref_clk,
  input  wire logic scl_line,
  input  wire logic sda_line,
  output logic      scl_low,
  output logic      sda_low
);
  int stall;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic half_per();
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic set_data(input logic b);
    @(posedge ref_clk);
    sda_low <= !b;
  endtask
  // Start: data falls while clock is high
  task automatic begin_frame();
    @(posedge ref_clk);
    sda_low <= 1'b1;
    half_per();
    scl_low <= 1'b1;
    half_per();
  endtask
  task automatic bit_cycle(input logic b, output logic seen);
    @(posedge ref_clk);
    sda_low <= !b;
    half_per();
    scl_low <= 1'b0;
    stall = 0;
    while (!scl_line && stall < 2000) begin
      @(posedge ref_clk);
      stall++;
    end
    half_per();
    seen = sda_line;
    scl_low <= 1'b1;
    half_per();
  endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import serial_shift_pkg::*;
;
  logic       ref_clk, rst_n, timer_match, port_data_out_bit, rx_ready;
  logic       data_out_pin_out, sda_oe, scl_oe, counter_overflow_out;
  logic       start_detect_out, rx_valid, scl_low, sda_low, seen, b;
  logic       data_out_dir, data_out_pin_oe;
  logic [7:0] reg_rdata, rx_data, byt, exp_d;
  logic [7:0] rxq[$];
  reg_req_t   reg_req;
  int         n_mismatch = 0, cmp_count = 0, cyc = 0, seed;
  wire        scl_line = !(scl_oe || scl_low);
  wire        sda_line = !(sda_oe || sda_low);
  serial_shift_two_wire_unit dut (
    .ref_clk, .rst_n, .reg_req, .reg_rdata, .timer_match,
    .serial_clock_pin_in(scl_line), .serial_in_pin(sda_line),
    .port_data_out_bit, .port_clock_out_bit(1'b1), .data_out_dir,
    .clock_dir(1'b1), .data_out_pin_out, .data_out_pin_oe, .sda_out(),
    .sda_oe, .scl_out(), .scl_oe, .counter_overflow_out, .start_detect_out,
    .rx_valid, .rx_ready, .rx_data);
  two_wire_master_model bm (
    .ref_clk, .scl_line, .sda_line, .scl_low, .sda_low);
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d,
                    input logic t = 1'b0);
    @(posedge ref_clk);
    reg_req <= '{1'b1, 1'b0, a, d};
    timer_match <= t;
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
    timer_match <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rdc(input logic [1:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge ref_clk);
    chk(reg_rdata, e);
  endtask
  task automatic pop();
    int k;
    k = 0;
    while (rx_valid !== 1'b1 && k < 50) begin
      @(negedge ref_clk);
      k++;
    end
    chkb(rx_valid, 1'b1);
    chk(rx_data, rxq.pop_front());
    @(posedge ref_clk);
    rx_ready <= 1'b1;
    @(posedge ref_clk);
    rx_ready <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    seed = 32'h5ACC;
    reg_req = '0;
    timer_match = 1'b0;
    port_data_out_bit = 1'b1;
    data_out_dir = 1'b1;
    rx_ready = 1'b0;
    rst_n = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdc(REG_CTRL, 8'h00);
    // Three-wire, software strobe clock
    byt = $random(seed);
    wr(REG_CTRL, 8'h10);
    wr(REG_DATA, byt);
    chkb(data_out_pin_out, byt[7]);
    chkb(data_out_pin_oe, 1'b1);
    @(posedge ref_clk);
    data_out_dir <= 1'b0;
    @(negedge ref_clk);
    chkb(data_out_pin_oe, 1'b0);
    @(posedge ref_clk);
    data_out_dir <= 1'b1;
    wr(REG_STATUS, 8'h48);
    exp_d = byt;
    for (int i = 0; i < 8; i++) begin
      b = $random(seed);
      bm.set_data(b);
      repeat (4) @(posedge ref_clk);
      wr(REG_CTRL, 8'h12);
      exp_d = {exp_d[6:0], b};
    end
    chkb(counter_overflow_out, 1'b1);
    rdc(REG_DATA, exp_d);
    rdc(REG_BUFFER, exp_d);
    rxq.push_back(exp_d);
    pop();
    // Timer clock against a data write
    byt = $random(seed);
    wr(REG_CTRL, 8'h14);
    wr(REG_DATA, byt, 1'b1);
    rdc(REG_DATA, byt);
    wr(REG_CTRL, 8'h14, 1'b1);
    rdc(REG_DATA, {byt[6:0], sda_line});
    rdc(REG_STATUS, 8'h42);
    // Two-wire slave receive, acknowledge
    bm.set_data(1'b1);
    wr(REG_DATA, 8'hFF);
    wr(REG_STATUS, 8'hE0);
    wr(REG_CTRL, 8'h38);
    bm.begin_frame();
    repeat (4) @(negedge ref_clk);
    chkb(start_detect_out, 1'b1);
    chkb(scl_oe, 1'b1);
    byt = $random(seed);
    wr(REG_STATUS, 8'h80);
    for (int i = 7; i >= 0; i--)
      bm.bit_cycle(byt[i], seen);
    repeat (6) @(negedge ref_clk);
    chkb(counter_overflow_out, 1'b1);
    chkb(scl_oe, 1'b1);
    rdc(REG_DATA, byt);
    rxq.push_back(byt);
    pop();
    wr(REG_DATA, 8'h00);
    wr(REG_STATUS, 8'h4E);
    bm.bit_cycle(1'b1, seen);
    chkb(seen, 1'b0);
    chkb(bm.stall < 2000, 1'b1);
    repeat (6) @(negedge ref_clk);
    chkb(scl_oe, 1'b1);
    rxq.push_back(8'h00);
    pop();
    wr(REG_DATA, 8'hFF);
    chkb(sda_oe, 1'b0);
    @(posedge ref_clk);
    port_data_out_bit <= 1'b0;
    repeat (2) @(negedge ref_clk);
    chkb(sda_oe, 1'b1);
    // Mode off, external clock, counter preset to maximum
    wr(REG_CTRL, 8'h08);
    wr(REG_STATUS, 8'h4F);
    b = $random(seed);
    bm.bit_cycle(b, seen);
    repeat (6) @(negedge ref_clk);
    chkb(counter_overflow_out, 1'b1);
    rdc(REG_DATA, {7'h7F, b});
    tally_and_finish();
  end
endmodule
`default_nettype wire
